// ---- common/sos_pkg.sv ----
// Package for the spindle orientation stop block
package sos_pkg;
  // ----------------------------------------
  // Position resolution
  // ----------------------------------------
  localparam int POS_W = 12;
  localparam logic [12:0] POS_STEPS = 13'h1000; // Steps per revolution
  localparam int SEL_BIT_POS_REF = 7; // Select word bit: position reference valid
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [11:0] CONST_POS_RESET = 12'h0000;
  localparam logic [11:0] DONE_WIDTH = 12'h0002; // In-position band, steps
  localparam logic [11:0] MAG_CENTER = 12'h0000; // Sensor centre offset
  // ----------------------------------------
  // Home reference source
  // ----------------------------------------
  typedef enum logic [1:0] {
    HOME_MOTOR_ENC,
    HOME_MAG_SENSOR,
    HOME_SPINDLE_ENC
  } sos_home_t;
  typedef enum {
    ST_SPEED,
    ST_TO_ORIENT_SPEED,
    ST_SEEK_REF,
    ST_POSITION,
    ST_HOLD
  } sos_state_t;
endpackage

// ---- rtl/sos_orient.sv ----
// Spindle orientation stop controller
`timescale 1ns/1ns
module sos_orient
  import sos_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Sequence inputs
  input wire logic ORIENT_REQUEST,
  input wire logic INCREMENTAL,
  input wire logic BCD_MODE,
  input wire logic [11:0] POS_REF,
  // Configuration
  input wire logic [7:0] STOP_REF_SELECT_WORD,
  input wire logic [11:0] CONST_POS,
  input wire logic [1:0] HOME_MODE,
  // Drive feedback
  input wire logic AT_ORIENT_SPEED,
  input wire logic MOTOR_INDEX,
  input wire logic MAG_SENSOR,
  input wire logic SPINDLE_INDEX,
  input wire logic [11:0] MOTOR_POS,
  input wire logic [11:0] SPINDLE_POS,
  input wire logic AT_REST,
  // Drive commands
  output logic ORIENT_SPEED_CMD,
  output logic POS_LOOP_ON,
  output logic [11:0] TARGET_POS,
  output logic ORIENT_DONE
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // BCD degrees (0..359) to 4096 steps per turn
  function automatic logic [11:0] bcd_to_steps(input logic [11:0] b);
    logic [21:0] deg;
    logic [21:0] prod;
    deg = 22'(b[11:8]) * 22'd100 + 22'(b[7:4]) * 22'd10 + 22'(b[3:0]);
    prod = deg * 22'(POS_STEPS);
    return 12'((prod / 22'd360) % 22'(POS_STEPS));
  endfunction
  // Absolute distance on the circle
  function automatic logic [11:0] circ_err(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = a - b;
    return d[11] ? (12'h000 - d) : d;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [6:0] s1_q, s2_q;
  logic [11:0] mp1_q, mp2_q, sp1_q, sp2_q;
  // Two-flop capture of pins
  // Position words share the pins' delay, so a hit sees the matching count
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s1_q <= '0;
      s2_q <= '0;
      mp1_q <= '0;
      mp2_q <= '0;
      sp1_q <= '0;
      sp2_q <= '0;
    end else begin
      s1_q <= {ORIENT_REQUEST, INCREMENTAL, AT_ORIENT_SPEED, MOTOR_INDEX,
               MAG_SENSOR, SPINDLE_INDEX, AT_REST};
      s2_q <= s1_q;
      mp1_q <= MOTOR_POS;
      mp2_q <= mp1_q;
      sp1_q <= SPINDLE_POS;
      sp2_q <= sp1_q;
    end
  end
  // Synchronised pin levels
  logic req, incr, at_speed, m_idx, mag, s_idx, rest;
  assign {req, incr, at_speed, m_idx, mag, s_idx, rest} = s2_q;

  // ----------------------------------------
  // Orientation state machine
  // ----------------------------------------
  sos_state_t state_q, state_d;
  logic req_q, req_d;
  logic homed_q, homed_d;
  logic [11:0] stop_q, stop_d;     // Current stop position
  logic [11:0] tgt_q, tgt_d;
  logic done_q, done_d;
  logic [11:0] cmd, fb, ref_hit;
  logic hit;
  sos_home_t home;

  // Command decode and reference select
  always_comb begin
    home = sos_home_t'(HOME_MODE);
    cmd = BCD_MODE ? bcd_to_steps(POS_REF) : POS_REF;
    if (!STOP_REF_SELECT_WORD[SEL_BIT_POS_REF]) cmd = CONST_POS;
    fb = (home == HOME_SPINDLE_ENC) ? sp2_q : mp2_q;
    case (home)
      HOME_MAG_SENSOR: hit = mag;
      HOME_SPINDLE_ENC: hit = s_idx;
      default: hit = m_idx;
    endcase
    ref_hit = (home == HOME_MAG_SENSOR) ? 12'(fb - MAG_CENTER) : fb;
  end

  // Next state; every value but the request copy holds unless a state changes it
  always_comb begin
    state_d = state_q;
    // Previous synced request, for rising-edge detection
    req_d = req;
    homed_d = homed_q;
    stop_d = stop_q;
    tgt_d = tgt_q;
    done_d = done_q;
    case (state_q)
      ST_SPEED: begin
        done_d = 1'b0;
        if (req && !req_q) begin
          if (incr && homed_q) begin
            // step from current stop
            // No search: the last stop is the reference
            tgt_d = 12'(stop_q + cmd);
            state_d = ST_POSITION;
          end else begin
            // Absolute move searches the reference again
            state_d = ST_TO_ORIENT_SPEED;
          end
        end
      end
      ST_TO_ORIENT_SPEED: begin
        // Index pulses are ignored until speed is reached
        // reach orientation speed
        if (!req) state_d = ST_SPEED;
        else if (at_speed) state_d = ST_SEEK_REF;
      end
      ST_SEEK_REF: begin
        if (!req) state_d = ST_SPEED;
        else if (hit) begin
          tgt_d = 12'(ref_hit + cmd);
          homed_d = 1'b1;
          state_d = ST_POSITION;
        end
      end
      ST_POSITION: begin
        done_d = 1'b0;
        // Done needs both rest and a small error, not either alone
        if (!req) state_d = ST_SPEED;
        else if (rest && circ_err(fb, tgt_q) <= DONE_WIDTH) begin
          done_d = 1'b1;
          stop_d = tgt_q;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // hold while requested
        // Loop stays closed against outside torque until release
        if (!req) begin
          done_d = 1'b0;
          state_d = ST_SPEED;
        end
      end
      default: state_d = ST_SPEED;
    endcase
  end

  // Registers; reset returns to speed control
  // Homed survives requests and clears only on reset
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_SPEED;
      req_q <= 1'b0;
      homed_q <= 1'b0;
      stop_q <= CONST_POS_RESET;
      tgt_q <= CONST_POS_RESET;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      homed_q <= homed_d;
      stop_q <= stop_d;
      tgt_q <= tgt_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // 12-bit step target
  assign TARGET_POS = tgt_q;
  // Done level straight from its register
  assign ORIENT_DONE = done_q;
  // Drive commands decoded from state
  assign ORIENT_SPEED_CMD = (state_q == ST_TO_ORIENT_SPEED) || (state_q == ST_SEEK_REF);
  assign POS_LOOP_ON = (state_q == ST_POSITION) || (state_q == ST_HOLD);
endmodule

// ---- tb/sos_drive_model.sv ----
// Behavioural drive and encoder model facing the orientation controller
`timescale 1ns/1ns
module sos_drive_model (
  // Clock
  input wire logic clk,
  // Commands from the controller
  input wire logic speed_cmd,
  input wire logic loop_on,
  input wire logic [11:0] target,
  // Feedback to the controller
  output logic at_speed,
  output logic index,
  output logic at_rest,
  output logic [11:0] pos
);
  logic [3:0] ramp = 4'h0;
  logic ph = 1'b0;
  initial pos = 12'h0FF0;
  // Index marks the zero point; counter wraps every revolution
  assign index = (pos == 12'h0000);
  assign at_speed = (ramp == 4'hF);
  assign at_rest = loop_on && (pos == target);
  // Slow speed ramp, creep during search, loop walks clockwise to target
  always @(negedge clk) begin
    ph <= ~ph;
    ramp <= !speed_cmd ? 4'h0 : at_speed ? ramp : ramp + 4'h1;
    if ((loop_on && !at_rest) || (speed_cmd && !loop_on && ph))
      pos <= pos + 12'h001;
  end
endmodule

// ---- tb/sos_orient_asserts.sv ----
// Checker on the orientation controller ports
`timescale 1ns/1ns
module sos_orient_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Sequence and configuration inputs
  input wire logic ORIENT_REQUEST,
  input wire logic INCREMENTAL,
  input wire logic [1:0] HOME_MODE,
  // Drive feedback
  input wire logic AT_ORIENT_SPEED,
  input wire logic MOTOR_INDEX,
  input wire logic AT_REST,
  // Controller outputs
  input wire logic ORIENT_SPEED_CMD,
  input wire logic POS_LOOP_ON,
  input wire logic ORIENT_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence idle_rise;
    $rose(ORIENT_REQUEST) && !POS_LOOP_ON && !ORIENT_SPEED_CMD;
  endsequence
  sequence rest_run;
    (POS_LOOP_ON && AT_REST && ORIENT_REQUEST) [*6];
  endsequence
  speed_up_a: assert property (idle_rise |-> ##[1:3] (ORIENT_SPEED_CMD || POS_LOOP_ON))
    else $error("no speed command");
  seek_index_a: assert property ($rose(POS_LOOP_ON) && HOME_MODE == 2'h0 && !INCREMENTAL
    |-> $past(AT_ORIENT_SPEED, 3) && ($past(MOTOR_INDEX, 3) || $past(MOTOR_INDEX, 4)))
    else $error("loop before index");
  done_rest_a: assert property (rest_run |-> ORIENT_DONE)
    else $error("done missing at rest");
  done_cause_a: assert property ($rose(ORIENT_DONE) |-> POS_LOOP_ON && $past(AT_REST, 3))
    else $error("done without rest");
  hold_loop_a: assert property (ORIENT_DONE |-> POS_LOOP_ON)
    else $error("done without loop");
  keep_done_a: assert property ($fell(ORIENT_DONE) |-> !$past(ORIENT_REQUEST, 3))
    else $error("done dropped early");
  release_idle_a: assert property ($fell(ORIENT_REQUEST)
    |-> ##3 !(ORIENT_DONE || POS_LOOP_ON || ORIENT_SPEED_CMD))
    else $error("outputs kept after release");
  loop_req_a: assert property (POS_LOOP_ON |-> $past(ORIENT_REQUEST, 3))
    else $error("loop without request");
endmodule
bind sos_orient sos_orient_asserts u_chk (
  .CLK(CLK),
  .SYS_RST(SYS_RST),
  .ORIENT_REQUEST(ORIENT_REQUEST),
  .INCREMENTAL(INCREMENTAL),
  .HOME_MODE(HOME_MODE),
  .AT_ORIENT_SPEED(AT_ORIENT_SPEED),
  .MOTOR_INDEX(MOTOR_INDEX),
  .AT_REST(AT_REST),
  .ORIENT_SPEED_CMD(ORIENT_SPEED_CMD),
  .POS_LOOP_ON(POS_LOOP_ON),
  .ORIENT_DONE(ORIENT_DONE)
);

// ---- tb/test_spindle_orientation_stop.sv ----
// Self-checking bench for the orientation controller
`timescale 1ns/1ns
module test_spindle_orientation_stop;
  logic clk = 0, rst = 1, req = 0, incr = 0, bcd = 0, spd, loop, done, at_spd, idx, rest;
  logic [1:0] mode = 2'h0;
  logic [7:0] sel = 8'h80;
  logic [11:0] pref = 12'h0000, cpos = 12'h0123, tgt, pos;
  int failures = 0, check_count = 0;
  sos_orient u_dut (.CLK(clk), .SYS_RST(rst), .ORIENT_REQUEST(req), .INCREMENTAL(incr),
    .BCD_MODE(bcd), .POS_REF(pref), .STOP_REF_SELECT_WORD(sel), .CONST_POS(cpos),
    .HOME_MODE(mode), .AT_ORIENT_SPEED(at_spd), .MOTOR_INDEX(idx), .MAG_SENSOR(idx),
    .SPINDLE_INDEX(idx), .MOTOR_POS(pos), .SPINDLE_POS(pos), .AT_REST(rest),
    .ORIENT_SPEED_CMD(spd), .POS_LOOP_ON(loop), .TARGET_POS(tgt), .ORIENT_DONE(done));
  sos_drive_model u_drive (.clk(clk), .speed_cmd(spd), .loop_on(loop), .target(tgt),
    .at_speed(at_spd), .index(idx), .at_rest(rest), .pos(pos));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [11:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Request, await done, check target and hold, then release
  task automatic orient(input logic [11:0] exp);
    int n;
    @(negedge clk) req = 1;
    for (n = 0; n < 12000 && done !== 1'b1; n++) @(negedge clk);
    if (n == 12000) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, done, 1'b1);
      tally_and_finish;
    end
    chk(tgt, exp);
    repeat (20) @(negedge clk);
    chk({10'h000, done, loop}, 12'h0003);
    req = 0;
    repeat (4) @(negedge clk);
    chk({9'h000, done, loop, spd}, 12'h0000);
  endtask
  task automatic t_absolute;
    pref = 12'h0400;
    orient(12'h0400);
    mode = 2'h2;
    orient(12'h0400);
    mode = 2'h0;
    $display("absolute finished");
  endtask
  task automatic t_incremental;
    incr = 1;
    pref = 12'h0010;
    orient(12'h0410);
    orient(12'h0420);
    incr = 0;
    $display("incremental finished");
  endtask
  // Magnetic homing, then an incremental step on the motor encoder
  task automatic t_magnetic;
    mode = 2'h1;
    pref = 12'h0400;
    orient(12'h0400 - sos_pkg::MAG_CENTER);
    incr = 1;
    pref = 12'h0010;
    orient(12'h0410 - sos_pkg::MAG_CENTER);
    incr = 0;
    mode = 2'h0;
    $display("magnetic finished");
  endtask
  task automatic t_bcd;
    bcd = 1;
    pref = 12'h0090;
    orient(12'h0400);
    bcd = 0;
    $display("bcd finished");
  endtask
  task automatic t_const;
    sel = 8'h00;
    pref = 12'h0777;
    orient(12'h0123);
    sel = 8'h80;
    $display("constant finished");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    t_absolute;
    t_incremental;
    t_magnetic;
    t_bcd;
    t_const;
    tally_and_finish;
  end
endmodule
